// ---- logic/framer_defines.svh ----
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH

// ----------------------------------------
// Line timing
// ----------------------------------------
`define FR_CLK_HZ      125000000
`define FR_BAUD        9600
`define FR_DATA_BITS   4'h8
`define FR_FRAME_BITS  4'hA

// ----------------------------------------
// Packet limits
// ----------------------------------------
`define FR_MAX_CHARS   8'h80
`define FR_FIFO_DEPTH  32
`define FR_FIFO_WIDTH  8
`define FR_ID_CAPTURE  2'h3

// ----------------------------------------
// Characters
// ----------------------------------------
`define CH_CR     8'h0D
`define CH_KEY    8'h21
`define CH_AT     8'h40
`define CH_ZERO   8'h30
`define CH_COLON  8'h3A
`define CH_SPACE  8'h20
`define CH_DOT    8'h2E
`define CH_R      8'h52
`define CH_E      8'h45
`define CH_A      8'h41
`define CH_L      8'h4C
`define CH_M      8'h4D
`define CH_D      8'h44
`define CH_B      8'h42
`define CH_H      8'h48
`define CH_S      8'h53
`define CH_Z      8'h5A

`endif

// ---- logic/framer_pkg.sv ----
package framer_pkg;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    PS_START = 2'b00,
    PS_KEYS  = 2'b01,
    PS_BODY  = 2'b10,
    PS_FWD   = 2'b11
  } parse_state_t;

  typedef enum logic [2:0] {
    G_IDLE  = 3'b000,
    G_HOST  = 3'b001,
    G_ID    = 3'b010,
    G_KEYS  = 3'b011,
    G_HDR   = 3'b100,
    G_SPACE = 3'b101,
    G_BODY  = 3'b110,
    G_CR    = 3'b111
  } gen_state_t;

  typedef enum logic [1:0] {
    RK_GENERAL = 2'b00,
    RK_ERROR   = 2'b01,
    RK_ALARM   = 2'b10
  } rsp_kind_t;

  typedef enum logic [2:0] {
    ENC_NONE = 3'b000,
    ENC_DEC  = 3'b001,
    ENC_BIN  = 3'b010,
    ENC_HEX  = 3'b011,
    ENC_STR  = 3'b100,
    ENC_OTH  = 3'b101
  } enc_t;

  typedef struct packed {
    rsp_kind_t  kind;
    logic [3:0] nfields;
    enc_t       enc;
    logic [7:0] main_bcd;
    logic [3:0] sub_code;
    logic [3:0] keys;
  } rsp_hdr_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       is_at;
  } cmd_beat_t;

  typedef struct packed {
    logic [3:0] keys;
    logic       is_at;
    logic       has_cmd;
  } pkt_info_t;

endpackage

// ---- logic/char_fifo.sv ----
`timescale 1ns/10ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic             do_wr;
  logic             do_rd;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
  assign out_valid = (wr_ptr_ff != rd_ptr_ff);
  assign out_data  = mem[rd_ptr_ff[AW-1:0]];
  assign do_wr     = ce && in_valid && in_ready;
  assign do_rd     = ce && out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
    end
  end
endmodule

// ---- logic/servo_ascii_serial_framer.sv ----
`timescale 1ns/10ps
`include "framer_defines.svh"
module servo_ascii_serial_framer
  import framer_pkg::*;
#(
  parameter int BIT_CYCLES = `FR_CLK_HZ / `FR_BAUD
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       rxd,
  output logic            txd_ff,
  input  wire logic [3:0] station_id_switch,
  output logic            multi_mode_ff,
  output logic [3:0]      own_id_ff,
  output cmd_beat_t       cmd_ff,
  output logic            cmd_valid_ff,
  output pkt_info_t       pkt_ff,
  output logic            pkt_done_ff,
  output logic            rx_frame_err_ff,
  output logic            fwd_ovf_ff,
  input  wire rsp_hdr_t   rsp_hdr,
  input  wire logic       rsp_start,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_field,
  input  wire logic       rsp_last,
  input  wire logic       rsp_valid,
  output logic            rsp_ready_ff,
  output logic            rsp_busy_ff
);
  localparam int HALF_CYCLES = BIT_CYCLES / 2;

  // ----------------------------------------
  // Pin synchronisers and ID strap
  // ----------------------------------------
  logic [1:0] rxd_sync_ff;
  logic [3:0] id_meta_ff;
  logic [3:0] id_sync_ff;
  logic [1:0] id_cnt_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxd_sync_ff <= 2'h3;
      id_meta_ff  <= 4'h0;
      id_sync_ff  <= 4'h0;
    end else if (ce) begin
      rxd_sync_ff <= {rxd_sync_ff[0], rxd};
      id_meta_ff  <= station_id_switch;
      id_sync_ff  <= id_meta_ff;
    end
  end

  // Switch only read once after reset, as at power-up
  // strap capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      id_cnt_ff     <= 2'h0;
      own_id_ff     <= 4'h0;
      multi_mode_ff <= 1'b0;
    end else if (ce && id_cnt_ff != `FR_ID_CAPTURE) begin
      id_cnt_ff <= id_cnt_ff + 2'h1;
      if (id_cnt_ff == `FR_ID_CAPTURE - 2'h1) begin
        own_id_ff     <= id_sync_ff;
        multi_mode_ff <= (id_sync_ff != 4'h0);
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  rx_state_t  rx_state_ff;
  logic [13:0] rx_cnt_ff;
  logic [2:0]  rx_bit_ff;
  logic [7:0]  rx_shift_ff;
  logic        rx_stb_ff;
  logic        rx_line;

  assign rx_line = rxd_sync_ff[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_state_ff     <= RX_IDLE;
      rx_cnt_ff       <= 14'h0;
      rx_bit_ff       <= 3'h0;
      rx_shift_ff     <= 8'h00;
      rx_stb_ff       <= 1'b0;
      rx_frame_err_ff <= 1'b0;
    end else if (ce) begin
      rx_stb_ff       <= 1'b0;
      rx_frame_err_ff <= 1'b0;
      if (rx_cnt_ff != 14'h0) begin
        rx_cnt_ff <= rx_cnt_ff - 14'h1;
      end else begin
        case (rx_state_ff)
          RX_IDLE: begin
            if (!rx_line) begin
              rx_state_ff <= RX_START;
              rx_cnt_ff   <= 14'(HALF_CYCLES - 1);
            end
          end
          RX_START: begin
            // Glitch shorter than half a bit is dropped
            rx_state_ff <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_ff   <= 14'(BIT_CYCLES - 1);
            rx_bit_ff   <= 3'h0;
          end
          RX_DATA: begin
            rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
            rx_cnt_ff   <= 14'(BIT_CYCLES - 1);
            rx_bit_ff   <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'(`FR_DATA_BITS - 4'h1)) begin
              rx_state_ff <= RX_STOP;
            end
          end
          default: begin
            rx_state_ff     <= RX_IDLE;
            rx_stb_ff       <= rx_line;
            rx_frame_err_ff <= !rx_line;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Packet parser and ring forwarding
  // ----------------------------------------
  parse_state_t ps_ff;
  logic [3:0]   key_cnt_ff;
  logic         is_at_ff;
  logic         fwd_valid_ff;
  logic [7:0]   fwd_byte_ff;
  logic         fwd_take;
  logic         in_keys;
  logic         fifo_in_ready;

  assign in_keys = (ps_ff == PS_KEYS) || (ps_ff == PS_START && !multi_mode_ff);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps_ff        <= PS_START;
      key_cnt_ff   <= 4'h0;
      is_at_ff     <= 1'b0;
      cmd_ff       <= '0;
      cmd_valid_ff <= 1'b0;
      pkt_ff       <= '0;
      pkt_done_ff  <= 1'b0;
      fwd_valid_ff <= 1'b0;
      fwd_byte_ff  <= 8'h00;
      fwd_ovf_ff   <= 1'b0;
    end else if (ce) begin
      cmd_valid_ff <= 1'b0;
      pkt_done_ff  <= 1'b0;
      if (fwd_take) begin
        fwd_valid_ff <= 1'b0;
      end
      if (rx_stb_ff) begin
        if (ps_ff == PS_FWD || (ps_ff == PS_START && multi_mode_ff &&
            rx_shift_ff != `CH_ZERO + {4'h0, own_id_ff})) begin
          fwd_byte_ff  <= rx_shift_ff;
          fwd_valid_ff <= 1'b1;
          fwd_ovf_ff   <= fwd_valid_ff && !fwd_take;
          ps_ff        <= (rx_shift_ff == `CH_CR) ? PS_START : PS_FWD;
        end else if (ps_ff == PS_START && multi_mode_ff) begin
          ps_ff      <= PS_KEYS;
          key_cnt_ff <= 4'h0;
        end else if (rx_shift_ff == `CH_CR) begin
          pkt_done_ff <= 1'b1;
          pkt_ff      <= '{keys: key_cnt_ff, is_at: is_at_ff && !in_keys,
                           has_cmd: !in_keys};
          ps_ff       <= PS_START;
          key_cnt_ff  <= 4'h0;
        end else if (in_keys && rx_shift_ff == `CH_KEY) begin
          key_cnt_ff <= key_cnt_ff + 4'h1;
          ps_ff      <= PS_KEYS;
        end else begin
          cmd_valid_ff <= 1'b1;
          cmd_ff       <= '{data: rx_shift_ff, first: in_keys,
                            is_at: in_keys ? (rx_shift_ff == `CH_AT) : is_at_ff};
          if (in_keys) begin
            is_at_ff <= (rx_shift_ff == `CH_AT);
          end
          ps_ff <= PS_BODY;
        end
      end
    end
  end

  // ----------------------------------------
  // Response generator
  // ----------------------------------------
  gen_state_t gen_ff;
  rsp_hdr_t   hdr_ff;
  logic [2:0] hidx_ff;
  logic [7:0] len_ff;
  logic [3:0] gkeys_ff;
  logic       gen_valid_ff;
  logic [7:0] gen_byte_ff;
  logic       sav_valid_ff;
  logic [7:0] sav_byte_ff;
  logic       sav_last_ff;
  logic       gen_take;
  logic [7:0] hdr_char;
  logic [2:0] hdr_last;
  logic [7:0] enc_char;

  always_comb begin
    case (hdr_ff.enc)
      ENC_NONE: enc_char = `CH_ZERO;
      ENC_DEC:  enc_char = `CH_D;
      ENC_BIN:  enc_char = `CH_B;
      ENC_HEX:  enc_char = `CH_H;
      ENC_STR:  enc_char = `CH_S;
      default:  enc_char = `CH_Z;
    endcase
  end

  always_comb begin
    hdr_last = (hdr_ff.kind == RK_GENERAL) ? 3'h2 : 3'h6;
    hdr_char = `CH_DOT;
    if (hdr_ff.kind == RK_GENERAL) begin
      case (hidx_ff)
        3'h0:    hdr_char = `CH_R;
        3'h1:    hdr_char = `CH_ZERO + {4'h0, hdr_ff.nfields};
        default: hdr_char = enc_char;
      endcase
    end else begin
      case (hidx_ff)
        3'h0:    hdr_char = (hdr_ff.kind == RK_ALARM) ? `CH_A : `CH_E;
        3'h1:    hdr_char = (hdr_ff.kind == RK_ALARM) ? `CH_L : `CH_R;
        3'h2:    hdr_char = (hdr_ff.kind == RK_ALARM) ? `CH_M : `CH_R;
        3'h3:    hdr_char = `CH_ZERO + {4'h0, hdr_ff.main_bcd[7:4]};
        3'h4:    hdr_char = `CH_ZERO + {4'h0, hdr_ff.main_bcd[3:0]};
        3'h5:    hdr_char = `CH_DOT;
        default: hdr_char = `CH_ZERO + {4'h0, hdr_ff.sub_code};
      endcase
    end
  end

  // Forwarded bytes win the FIFO; they cannot be stalled
  assign fwd_take = fwd_valid_ff && fifo_in_ready;
  assign gen_take = gen_valid_ff && fifo_in_ready && !fwd_valid_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gen_ff       <= G_IDLE;
      hdr_ff       <= '0;
      hidx_ff      <= 3'h0;
      len_ff       <= 8'h00;
      gkeys_ff     <= 4'h0;
      gen_valid_ff <= 1'b0;
      gen_byte_ff  <= 8'h00;
      sav_valid_ff <= 1'b0;
      sav_byte_ff  <= 8'h00;
      sav_last_ff  <= 1'b0;
      rsp_ready_ff <= 1'b0;
      rsp_busy_ff  <= 1'b0;
    end else if (ce) begin
      if (gen_take) begin
        gen_valid_ff <= 1'b0;
        len_ff       <= len_ff + 8'h01;
      end else if (!gen_valid_ff) begin
        case (gen_ff)
          G_IDLE: begin
            if (rsp_start) begin
              hdr_ff      <= rsp_hdr;
              gkeys_ff    <= rsp_hdr.keys;
              hidx_ff     <= 3'h0;
              len_ff      <= 8'h00;
              rsp_busy_ff <= 1'b1;
              gen_ff      <= multi_mode_ff ? G_HOST : G_KEYS;
            end
          end
          G_HOST: begin
            gen_byte_ff  <= `CH_ZERO;
            gen_valid_ff <= 1'b1;
            gen_ff       <= G_ID;
          end
          G_ID: begin
            gen_byte_ff  <= `CH_ZERO + {4'h0, own_id_ff};
            gen_valid_ff <= 1'b1;
            gen_ff       <= G_KEYS;
          end
          G_KEYS: begin
            if (gkeys_ff != 4'h0) begin
              gen_byte_ff  <= `CH_KEY;
              gen_valid_ff <= 1'b1;
              gkeys_ff     <= gkeys_ff - 4'h1;
            end else begin
              gen_ff <= G_HDR;
            end
          end
          G_HDR: begin
            gen_byte_ff  <= hdr_char;
            gen_valid_ff <= 1'b1;
            hidx_ff      <= hidx_ff + 3'h1;
            if (hidx_ff == hdr_last) begin
              gen_ff <= G_SPACE;
            end
          end
          G_SPACE: begin
            gen_byte_ff  <= `CH_SPACE;
            gen_valid_ff <= 1'b1;
            gen_ff       <= G_BODY;
          end
          G_BODY: begin
            if (sav_valid_ff) begin
              gen_byte_ff  <= sav_byte_ff;
              gen_valid_ff <= 1'b1;
              sav_valid_ff <= 1'b0;
              if (sav_last_ff) begin
                gen_ff <= G_CR;
              end
            end else if (rsp_ready_ff && rsp_valid) begin
              rsp_ready_ff <= 1'b0;
              // drop text past the limit, keep CR room
              if (len_ff + (rsp_field ? 8'h02 : 8'h01) < `FR_MAX_CHARS) begin
                gen_byte_ff  <= rsp_field ? `CH_COLON : rsp_data;
                gen_valid_ff <= 1'b1;
                sav_valid_ff <= rsp_field;
                sav_byte_ff  <= rsp_data;
                sav_last_ff  <= rsp_last;
                if (rsp_last && !rsp_field) begin
                  gen_ff <= G_CR;
                end
              end else if (rsp_last) begin
                gen_ff <= G_CR;
              end
            end else begin
              rsp_ready_ff <= 1'b1;
            end
          end
          default: begin
            gen_byte_ff  <= `CH_CR;
            gen_valid_ff <= 1'b1;
            rsp_busy_ff  <= 1'b0;
            gen_ff       <= G_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Transmit FIFO and transmitter
  // ----------------------------------------
  logic [7:0] fifo_out_data;
  logic       fifo_out_valid;
  logic       tx_busy_ff;
  logic [13:0] tx_cnt_ff;
  logic [3:0]  tx_bit_ff;
  logic [9:0]  tx_shift_ff;

  char_fifo #(
    .WIDTH (`FR_FIFO_WIDTH),
    .DEPTH (`FR_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_data   (fwd_valid_ff ? fwd_byte_ff : gen_byte_ff),
    .in_valid  (fwd_valid_ff || gen_valid_ff),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (!tx_busy_ff)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_busy_ff  <= 1'b0;
      tx_cnt_ff   <= 14'h0;
      tx_bit_ff   <= 4'h0;
      tx_shift_ff <= 10'h3FF;
      txd_ff      <= 1'b1;
    end else if (ce) begin
      if (!tx_busy_ff) begin
        if (fifo_out_valid) begin
          tx_busy_ff  <= 1'b1;
          tx_shift_ff <= {1'b1, fifo_out_data, 1'b0};
          tx_bit_ff   <= 4'h0;
          tx_cnt_ff   <= 14'h0;
        end
      end else if (tx_cnt_ff != 14'h0) begin
        tx_cnt_ff <= tx_cnt_ff - 14'h1;
      end else if (tx_bit_ff == `FR_FRAME_BITS) begin
        tx_busy_ff <= 1'b0;
      end else begin
        txd_ff      <= tx_shift_ff[0];
        tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
        tx_bit_ff   <= tx_bit_ff + 4'h1;
        tx_cnt_ff   <= 14'(BIT_CYCLES - 1);
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_gen_step(gen_state_t st);
    gen_ff == st && !gen_valid_ff && ce;
  endsequence

  property p_start_bit;
    @(posedge clk) disable iff (!rst_n || !ce)
    (tx_busy_ff && tx_cnt_ff == 14'h0 && tx_bit_ff == 4'h0) |=> !txd_ff;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");

  property p_bit_len;
    @(posedge clk) disable iff (!rst_n)
    tx_cnt_ff <= 14'(BIT_CYCLES - 1);
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit period overrun");

  property p_cr_last;
    @(posedge clk) disable iff (!rst_n || !ce)
    s_gen_step(G_CR) |=> gen_valid_ff && gen_byte_ff == `CH_CR && gen_ff == G_IDLE;
  endproperty
  a_cr_last: assert property (p_cr_last) else $error("response not ended by CR");

  property p_host_zero;
    @(posedge clk) disable iff (!rst_n || !ce)
    s_gen_step(G_HOST) |=> gen_byte_ff == `CH_ZERO && gen_ff == G_ID;
  endproperty
  a_host_zero: assert property (p_host_zero) else $error("host ID missing");

  property p_own_id;
    @(posedge clk) disable iff (!rst_n || !ce)
    s_gen_step(G_ID) |=> gen_byte_ff == `CH_ZERO + {4'h0, own_id_ff};
  endproperty
  a_own_id: assert property (p_own_id) else $error("wrong station digit");

  property p_len_limit;
    @(posedge clk) disable iff (!rst_n)
    len_ff <= `FR_MAX_CHARS;
  endproperty
  a_len_limit: assert property (p_len_limit) else $error("response too long");

  property p_key_wrap;
    @(posedge clk) disable iff (!rst_n || !ce)
    (rx_stb_ff && in_keys && rx_shift_ff == `CH_KEY && ps_ff != PS_FWD &&
     !(ps_ff == PS_START && multi_mode_ff))
    |=> key_cnt_ff == $past(key_cnt_ff) + 4'h1;
  endproperty
  a_key_wrap: assert property (p_key_wrap) else $error("key count off");

  property p_forward;
    @(posedge clk) disable iff (!rst_n || !ce)
    (rx_stb_ff && ps_ff == PS_FWD) |=> fwd_valid_ff && fwd_byte_ff == $past(rx_shift_ff);
  endproperty
  a_forward: assert property (p_forward) else $error("byte not forwarded");

  property p_space;
    @(posedge clk) disable iff (!rst_n || !ce)
    s_gen_step(G_SPACE) |=> gen_byte_ff == `CH_SPACE ##1 gen_ff == G_BODY;
  endproperty
  a_space: assert property (p_space) else $error("space missing");

  property p_at_class;
    @(posedge clk) disable iff (!rst_n || !ce)
    (cmd_valid_ff && cmd_ff.first) |-> cmd_ff.is_at == (cmd_ff.data == `CH_AT);
  endproperty
  a_at_class: assert property (p_at_class) else $error("command class wrong");
endmodule

// ---- dv/host_uart_model.sv ----
`timescale 1ns/10ps
module host_uart_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic line_rx,
  output logic      line_tx
);
  // ----------------------------------------
  // Host side of the serial line
  // ----------------------------------------
  logic [7:0] got_q[$];
  logic [7:0] rx_b;

  initial line_tx = 1'b1;

  // raw frame, LSB first; a low stop bit is followed by idle
  task automatic send_frame(input logic [9:0] fr);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_tx <= fr[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    if (!fr[9]) begin
      @(posedge clk);
      line_tx <= 1'b1;
      repeat (2 * BIT_CYCLES - 1) @(posedge clk);
    end
  endtask

  // start, 8 data, one stop, no flow control
  task automatic send_byte(input logic [7:0] b);
    send_frame({1'b1, b, 1'b0});
  endtask

  // mid-bit sampling; a low stop bit drops the byte
  always begin
    @(negedge line_rx);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      rx_b[i] = line_rx;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    if (line_rx) got_q.push_back(rx_b);
  end
endmodule

// ---- dv/servo_ascii_serial_framer_bench.sv ----
`timescale 1ns/10ps
module servo_ascii_serial_framer_bench import framer_pkg::*; ;
  // Short bit time keeps the run small
  localparam int BC = 8;
  logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rxd, txd_ff, multi_mode_ff;
  logic       cmd_valid_ff, pkt_done_ff, rx_frame_err_ff, fwd_ovf_ff;
  logic       rsp_start = 1'b0, rsp_field = 1'b0, rsp_last = 1'b0, rsp_valid = 1'b0;
  logic       rsp_ready_ff, rsp_busy_ff;
  logic [3:0] station_id_switch = 4'h0, own_id_ff;
  logic [7:0] rsp_data = 8'h00;
  cmd_beat_t  cmd_ff;
  pkt_info_t  pkt_ff;
  rsp_hdr_t   rsp_hdr = '0;
  logic [8:0] cmd_q[$];
  pkt_info_t  pkt_q[$];
  logic [7:0] exp_q[$];
  int         num_errors = 0, checks_done = 0, cyc = 0, ferr = 0;
  int         kc[4] = '{0, 15, 16, 17};
  string      b;

  always #4 clk = ~clk;

  servo_ascii_serial_framer #(.BIT_CYCLES(BC)) servo_ascii_serial_framer_inst (
    .clk, .rst_n, .ce, .rxd, .txd_ff, .station_id_switch, .multi_mode_ff, .own_id_ff,
    .cmd_ff, .cmd_valid_ff, .pkt_ff, .pkt_done_ff, .rx_frame_err_ff, .fwd_ovf_ff,
    .rsp_hdr, .rsp_start, .rsp_data, .rsp_field, .rsp_last, .rsp_valid,
    .rsp_ready_ff, .rsp_busy_ff
  );

  host_uart_model #(.BIT_CYCLES(BC)) host_uart_model_inst (
    .clk(clk), .line_rx(txd_ff), .line_tx(rxd)
  );

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk_rx(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t rx side got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_tx(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t tx char got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Pulses stand one cycle: sampled mid-cycle
  always @(negedge clk) begin
    if (cmd_valid_ff === 1'b1) cmd_q.push_back({cmd_ff.data, cmd_ff.first});
    if (pkt_done_ff === 1'b1) pkt_q.push_back(pkt_ff);
    if (rx_frame_err_ff === 1'b1) ferr++;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Scenario tasks
  // ----------------------------------------
  task automatic put(input string s);
    foreach (s[i]) exp_q.push_back(s[i]);
  endtask

  task automatic chk_bytes();
    while (host_uart_model_inst.got_q.size() < exp_q.size()) @(posedge clk);
    repeat (24 * BC) @(posedge clk);
    chk_tx(8'(host_uart_model_inst.got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) chk_tx(host_uart_model_inst.got_q[i], exp_q[i]);
  endtask

  task automatic do_reset(input logic [3:0] sw);
    rst_n <= 1'b0;
    station_id_switch <= sw;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk_rx(9'(multi_mode_ff), 9'(sw != 4'h0));
    chk_rx(9'(own_id_ff), 9'(sw));
  endtask

  // Packet text without CR; p skips a leading ID digit
  task automatic run_pkt(input string s, input int p);
    int k;
    int n;
    k = 0;
    while (s[p] == "!") begin
      k++;
      p++;
    end
    cmd_q.delete();
    pkt_q.delete();
    foreach (s[i]) host_uart_model_inst.send_byte(s[i]);
    host_uart_model_inst.send_byte(8'h0D);
    repeat (4 * BC) @(posedge clk);
    n = s.len() - p;
    chk_rx(9'(cmd_q.size()), 9'(n));
    foreach (cmd_q[i]) chk_rx(cmd_q[i], {s[p+i], i == 0});
    chk_rx(9'(pkt_q.size()), 9'h001);
    chk_rx(9'(pkt_q[0]), {3'h0, 4'(k), s[p] == "@", n > 0});
  endtask

  task automatic run_fwd(input string s);
    host_uart_model_inst.got_q.delete();
    cmd_q.delete();
    pkt_q.delete();
    exp_q.delete();
    put(s);
    exp_q.push_back(8'h0D);
    foreach (exp_q[i]) host_uart_model_inst.send_byte(exp_q[i]);
    chk_bytes();
    chk_rx(9'(cmd_q.size() + pkt_q.size()), 9'h000);
    chk_rx(9'(fwd_ovf_ff), 9'h000);
  endtask

  // A colon in body marks the next char as a field start
  task automatic run_rsp(input rsp_kind_t kd, input logic [3:0] nf, input enc_t en,
                         input logic [7:0] mb, input logic [3:0] sb, input logic [3:0] ky,
                         input string body);
    string es;
    bit    f;
    es = "0DBHSZ";
    f = 1'b0;
    exp_q.delete();
    host_uart_model_inst.got_q.delete();
    if (station_id_switch != 4'h0) exp_q = {8'h30, 8'h30 + 8'(station_id_switch)};
    repeat (ky) exp_q.push_back(8'h21);
    if (kd == RK_GENERAL) exp_q = {exp_q, 8'h52, 8'h30 + 8'(nf), es[int'(en)]};
    else begin
      put(kd == RK_ERROR ? "ERR" : "ALM");
      exp_q = {exp_q, 8'h30 + 8'(mb[7:4]), 8'h30 + 8'(mb[3:0]), 8'h2E, 8'h30 + 8'(sb)};
    end
    put({" ", body});
    if (exp_q.size() > 127) exp_q = exp_q[0:126];
    exp_q.push_back(8'h0D);
    rsp_hdr <= '{kd, nf, en, mb, sb, ky};
    do @(negedge clk); while (rsp_busy_ff !== 1'b0);
    @(posedge clk) rsp_start <= 1'b1;
    do @(negedge clk); while (rsp_busy_ff !== 1'b1);
    @(posedge clk) rsp_start <= 1'b0;
    for (int i = 0; i < body.len(); i++) begin
      if (body[i] == ":") begin
        f = 1'b1;
        continue;
      end
      rsp_data <= body[i];
      rsp_field <= f;
      rsp_last <= (i == body.len() - 1);
      rsp_valid <= 1'b1;
      do @(negedge clk); while (rsp_ready_ff !== 1'b1);
      @(posedge clk);
      f = 1'b0;
    end
    rsp_valid <= 1'b0;
    rsp_last <= 1'b0;
    chk_bytes();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(2));
    do_reset(4'h0);
    foreach (kc[j]) begin
      b = "";
      repeat (kc[j]) b = {b, "!"};
      run_pkt({b, "@3:1"}, 0);
    end
    run_pkt("!!#29", 0);
    run_pkt("!!!", 0);
    // Low stop bit: byte must vanish, next packet unharmed
    host_uart_model_inst.send_frame({1'b0, 8'h41, 1'b0});
    run_pkt("@4", 0);
    chk_rx(9'(ferr), 9'h001);
    for (int e = 0; e < 6; e++) begin
      b = "Pa:x";
      b[3] = 8'h41 + 8'($urandom % 26);
      run_rsp(RK_GENERAL, 4'($urandom % 10), enc_t'(e), 8'h00, 4'h0,
              4'($urandom), b);
    end
    run_rsp(RK_ERROR, 4'h0, ENC_NONE, 8'h30, 4'h0, 4'h1, "Servo");
    run_rsp(RK_ALARM, 4'h0, ENC_NONE, 8'h60, 4'h7, 4'h0, "Cmd");
    b = "";
    repeat (140) b = {b, "y"};
    run_rsp(RK_GENERAL, 4'h1, ENC_STR, 8'h00, 4'h0, 4'hF, b);
    do_reset(4'h5);
    run_pkt("5!!@1", 1);
    run_fwd("3!@2");
    run_rsp(RK_GENERAL, 4'h1, ENC_DEC, 8'h00, 4'h0, 4'h2, "Q:9");
    end_of_test();
  end
endmodule
